// [rtl/evc_top.sv]
/*
  Encoder velocity counter with AXI4-Lite register slave and interrupt.
  Assumes position step and direction come from counting logic on aclk.
*/
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "evc_defs.svh"
module evc_top
  import evc_pkg::*;
(
  // Clock, synchronous reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Step strobe and direction from the position counting logic
  input wire logic pos_step,
  input wire logic pos_dir_fwd,
  // Inputs the count must ignore; the mode is only shown for reading
  input wire logic index_pulse,
  input wire logic [2:0] position_init_mode_select,
  // Write address, data and response channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Level interrupt
  output logic irq
);
  // Write channel holding registers
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  // Read channel state and data
  evc_rd_state_t rd_state_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  // Sticky wrap status and its interrupt enable
  logic status_q;
  logic mask_q;
  // Count and wrap pulse from the accumulator
  logic [31:0] vel_count;
  logic vel_wrap;

  // Write channel acceptance; ce gates the readies so that nothing
  // is accepted while the state is frozen
  wire aw_take = ce && s_axi_awvalid && !aw_held_q && !bvalid_q;
  wire w_take = ce && s_axi_wvalid && !w_held_q && !bvalid_q;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire b_done = bvalid_q && s_axi_bready;
  wire wr_vel = wr_go && aw_addr_q == `EVC_OFF_VELOCITY;
  wire wr_stat = wr_go && aw_addr_q == `EVC_OFF_STATUS;
  wire wr_mask = wr_go && aw_addr_q == `EVC_OFF_MASK;
  // Unmapped offsets answer SLVERR
  wire wr_ok = wr_vel || wr_stat || wr_mask ||
               (wr_go && aw_addr_q == `EVC_OFF_CONTROL);
  wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] vel_wval = (w_data_q & strb_mask) | (vel_count & ~strb_mask);

  // Read decode; address bits 1:0 are ignored as on the write side
  wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
  wire ar_take = ce && s_axi_arvalid && rd_state_q == EVC_RD_IDLE;
  wire rd_vel = ar_take && ar_word == `EVC_OFF_VELOCITY;
  wire rd_stat = ar_take && ar_word == `EVC_OFF_STATUS;
  wire rd_mask = ar_take && ar_word == `EVC_OFF_MASK;
  wire rd_ctl = ar_take && ar_word == `EVC_OFF_CONTROL;
  // Unmapped offsets read as zero
  wire [31:0] rd_mux = rd_vel ? vel_count :
                       rd_stat ? {31'h0000_0000, status_q} :
                       rd_mask ? {31'h0000_0000, mask_q} :
                       rd_ctl ? {29'h0000_0000, position_init_mode_select} :
                       32'h0000_0000;
  wire rd_ok = rd_vel || rd_stat || rd_mask || rd_ctl;

  // Clear on read; a same-cycle step survives. Index and mode are not wired in.
  // A write load wins over a step in the same cycle
  evc_step_acc #(
    .WIDTH(32)
  ) u_acc (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .step(pos_step),
    .dir_fwd(pos_dir_fwd),
    .clear(rd_vel),
    .load(wr_vel),
    .load_value(vel_wval),
    .count(vel_count),
    .wrap(vel_wrap)
  );

  // Write path registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (b_done)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read path state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_q <= EVC_RD_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end
    else if (ce)
    begin
      case (rd_state_q)
        EVC_RD_IDLE:
        begin
          if (ar_take)
          begin
            rd_state_q <= EVC_RD_RESP;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? 2'b00 : 2'b10;
          end
        end
        EVC_RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state_q <= EVC_RD_IDLE;
          end
        end
        default:
        begin
          rd_state_q <= EVC_RD_IDLE;
        end
      endcase
    end
  end

  // Write one to clear the wrap flag; status and mask use byte lane 0 only
  wire wrap_clear = wr_stat && w_strb_q[0] && w_data_q[`EVC_BIT_WRAP];
  wire mask_load = wr_mask && w_strb_q[0];

  // Sticky wrap status, set wins over a same-cycle clear; mask is the enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= 1'b0;
      mask_q <= 1'b0;
    end
    else if (ce)
    begin
      status_q <= vel_wrap || (status_q && !wrap_clear);
      if (mask_load)
      begin
        mask_q <= w_data_q[`EVC_BIT_WRAP];
      end
    end
  end

  // Interrupt while an enabled status bit is set
  assign irq = status_q && mask_q;

  // Readies are combinational, responses come from registers
  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid = rd_state_q == EVC_RD_RESP;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : evc_top

// [rtl/evc_defs.svh]
/*
  Offsets, field positions, reset values for the encoder velocity counter.
  Assumes byte addressing on a 32-bit AXI4-Lite register bus.
*/
`ifndef EVC_DEFS_SVH
`define EVC_DEFS_SVH
`define EVC_OFF_VELOCITY 8'h00
`define EVC_OFF_STATUS 8'h04
`define EVC_OFF_MASK 8'h08
`define EVC_OFF_CONTROL 8'h0C
`define EVC_BIT_WRAP 0
`define EVC_VEL_RESET 32'h0000_0000
`define EVC_POS_MAX 32'h7FFF_FFFF
`define EVC_NEG_MIN 32'h8000_0000
`endif

// [rtl/evc_pkg.sv]
/*
  Types shared by the encoder velocity counter files.
  Assumes nothing beyond the defs header.
*/
package evc_pkg;
  typedef enum logic [1:0] {EVC_RD_IDLE, EVC_RD_RESP} evc_rd_state_t;
  typedef logic [31:0] evc_word_t;
endpackage : evc_pkg

// [rtl/evc_step_acc.sv]
/*
  Signed step accumulator with wrap detection and clear.
  Assumes step strobes are synchronous to aclk.
*/
`timescale 1ns/1ns
`include "evc_defs.svh"
module evc_step_acc
  import evc_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic step,
  input wire logic dir_fwd,
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] base;
  logic [WIDTH-1:0] stepped;
  logic wrap_d;
  logic wrap_q;
  logic [WIDTH-1:0] max_pos;
  logic [WIDTH-1:0] min_neg;

  // Read clear restarts from zero but keeps a step taken in the same cycle
  assign max_pos = {1'b0, {(WIDTH-1){1'b1}}};
  assign min_neg = {1'b1, {(WIDTH-1){1'b0}}};
  assign base = clear ? '0 : count_q;
  assign stepped = dir_fwd ? base + 1'b1 : base - 1'b1;
  assign count_d = load ? load_value : (step ? stepped : base);
  // Wrap across the signed limits in either direction
  assign wrap_d = step && !load && ((dir_fwd && base == max_pos) ||
                  (!dir_fwd && base == min_neg));

  // Count register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= '0;
      wrap_q <= 1'b0;
    end
    else if (ce)
    begin
      count_q <= count_d;
      wrap_q <= wrap_d;
    end
  end

  assign count = count_q;
  assign wrap = wrap_q;
endmodule : evc_step_acc

// [verification/evc_step_src.sv]
/*
  Step source standing in for the position counting logic.
  Assumes the bench calls move from a process synced to aclk.
*/
`timescale 1ns/1ns
module evc_step_src (
  input wire logic aclk,
  output logic pos_step,
  output logic pos_dir_fwd
);
  // Idle levels from time zero so the count never sees an unknown step
  initial
  begin
    pos_step <= 1'h0;
    pos_dir_fwd <= 1'h1;
  end

  // Steps n times, gap idle cycles apart; direction inverts when idle
  // One idle edge closes each move so back to back moves never collide
  task automatic move(input int n, input logic fwd, input int gap);
    repeat (n)
    begin
      pos_step <= 1'h1;
      pos_dir_fwd <= fwd;
      @(posedge aclk);
      if (gap > 0)
      begin
        pos_step <= 1'h0;
        pos_dir_fwd <= !fwd;
        repeat (gap) @(posedge aclk);
      end
    end
    pos_step <= 1'h0;
    pos_dir_fwd <= !fwd;
    @(posedge aclk);
  endtask : move
endmodule : evc_step_src

// [verification/evc_top_sva.sv]
/*
  Port checker for the encoder velocity counter.
  Assumes one clock aclk and synchronous active low aresetn.
*/
`timescale 1ns/1ns
module evc_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pos_step,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Bus timing, then interrupt cause and persistence
  rst_idle_a: assert property ($rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs active after reset");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  irq_cause_a: assert property ($rose(irq) |-> $past(pos_step, 2) || $rose(s_axi_bvalid))
    else $error("interrupt without cause");
  irq_keep_a: assert property (irq |=> irq || $rose(s_axi_bvalid))
    else $error("interrupt dropped without write");
  cover property (irq);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : evc_top_chk
bind evc_top evc_top_chk evc_top_chk_inst (.*);

// [verification/test_encoder_velocity_counter.sv]
/*
  Self-checking bench for the encoder velocity counter.
  Assumes the step source model and the checker bind are compiled.
*/
`timescale 1ns/1ns
`include "evc_defs.svh"
module test_encoder_velocity_counter import evc_pkg::*;;
  logic aclk, aresetn, ce, pos_step, pos_dir_fwd, index_pulse, irq;
  logic [2:0] position_init_mode_select;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, b;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  evc_word_t s_axi_wdata, s_axi_rdata, d;
  int err_count, num_checks, cyc;
  evc_top evc_top_inst (.*);
  evc_step_src evc_step_src_inst (.*);
  // Clock and hang limit
  always #4 aclk = !aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input evc_word_t seen, input evc_word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("mismatches %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Bus tasks hold each channel until its handshake edge
  task automatic wr(input logic [7:0] a, input evc_word_t v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    b = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task automatic t_count;
    rd(8'h00);
    chk(d, `EVC_VEL_RESET);
    evc_step_src_inst.move(5, 1'h1, 0);
    evc_step_src_inst.move(2, 1'h0, 2);
    rd(8'h00);
    chk(d, 32'h0000_0003);
    rd(8'h00);
    chk(d, 32'h0000_0000);
    evc_step_src_inst.move(3, 1'h0, 1);
    rd(8'h00);
    chk(d, 32'hFFFF_FFFD);
    rd(8'h10);
    chk({d[31:2], s_axi_rresp}, 32'h0000_0002);
    wr(8'h10, 32'h0000_0000);
    chk({30'h0, b}, 32'h0000_0002);
  endtask : t_count
  task automatic t_index;
    index_pulse <= 1'h1;
    position_init_mode_select <= 3'h5;
    evc_step_src_inst.move(2, 1'h1, 0);
    index_pulse <= 1'h0;
    rd(8'h00);
    chk(d, 32'h0000_0002);
    rd(8'h0C);
    chk(d, 32'h0000_0005);
  endtask : t_index
  task automatic t_wrap;
    wr(8'h00, `EVC_POS_MAX);
    chk({30'h0, b}, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    evc_step_src_inst.move(1, 1'h1, 0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h00);
    chk(d, `EVC_NEG_MIN);
    wr(8'h04, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(8'h00, `EVC_NEG_MIN);
    wr(8'h08, 32'h0000_0000);
    evc_step_src_inst.move(1, 1'h0, 0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(8'h04);
    chk(d, 32'h0000_0001);
    rd(8'h00);
    chk(d, `EVC_POS_MAX);
  endtask : t_wrap
  // Steps and bus requests while ce is low leave the state untouched
  task automatic t_freeze;
    evc_step_src_inst.move(2, 1'h1, 0);
    ce <= 1'h0;
    evc_step_src_inst.move(4, 1'h1, 0);
    fork
      rd(8'h00);
      begin
        repeat (3) @(posedge aclk);
        chk({31'h0, s_axi_arready}, 32'h0000_0000);
        ce <= 1'h1;
      end
    join
    chk(d, 32'h0000_0002);
  endtask : t_freeze
  // Reset in mid-run clears the count and the interrupt
  task automatic t_reset;
    wr(8'h08, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    evc_step_src_inst.move(3, 1'h1, 0);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(8'h00);
    chk(d, `EVC_VEL_RESET);
  endtask : t_reset
  // Reset, then the scenarios
  initial
  begin
    aclk = 1'h0;
    {ce, aresetn, index_pulse, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 6'h20;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} <= 6'h0F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, position_init_mode_select} <= '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_count();
    t_index();
    t_freeze();
    t_wrap();
    t_reset();
    finish_test();
  end
endmodule : test_encoder_velocity_counter
